// >>> hdl/acl_pkg.sv
/*
 package of the attitude command logic: command classes, command
 codes, register indices, status bit positions, reset value and reject counter limit.
 assumes a single 200 MHz core clock and synchronous command ports.
*/
// What this block does
// - keep enable/inhibit state; control pulses, maneuver starts and automatic roll search happen only while enabled.
// - high-gate override command toggles acceptance of brighter stars.
// - low-gate override command toggles acceptance of dimmer stars.
// - roll search auto and bypass flags pick automatic, forced on, off.
// - roll turn mode flag picks calibration or search rate for next turn.
// - star sensor auto and bypass flags pick automatic, forced on, off.
// - roll override rejects current star and restarts roll search.
// - quantitative cone command loads magnitude and drives the cone angle.
// - each cone step command moves the cone angle by the configured step size, saturating at either end.
// - heater auto and bypass flags pick automatic, commanded on, off.
// - gyro auto and bypass flags pick automatic, commanded on, off.
// - two control mode flags pick automatic, inertial, pitch/yaw inertial or cruise mode.
// - initiate maneuver starts turning with the stored turn register.
// - sequencer stored commands start positive and negative pitch turns.
// - each command class is accepted only from its allowed source.
package acl_pkg;
	// command classes
	localparam logic [1:0] CLS_QUANT = 2'h0;
	localparam logic [1:0] CLS_EITHER = 2'h1;
	localparam logic [1:0] CLS_DECODER = 2'h2;
	localparam logic [1:0] CLS_STORED = 2'h3;
	// command codes within a class
	localparam logic [4:0] EC_ENABLE = 5'h01;
	localparam logic [4:0] EC_ROLL_MODE = 5'h02;
	localparam logic [4:0] EC_HEAT_BYP = 5'h03;
	localparam logic [4:0] EC_GYRO_BYP = 5'h04;
	localparam logic [4:0] EC_MODE_ALL = 5'h05;
	localparam logic [4:0] EC_MODE_PY = 5'h06;
	localparam logic [4:0] EC_CONE_UP = 5'h0b;
	localparam logic [4:0] EC_CONE_DN = 5'h0c;
	localparam logic [4:0] DC_HI_GATE = 5'h01;
	localparam logic [4:0] DC_LO_GATE = 5'h02;
	localparam logic [4:0] DC_RS_AUTO = 5'h03;
	localparam logic [4:0] DC_RS_BYP = 5'h04;
	localparam logic [4:0] DC_SS_AUTO = 5'h05;
	localparam logic [4:0] DC_SS_BYP = 5'h06;
	localparam logic [4:0] DC_ROLL_OVR = 5'h07;
	localparam logic [4:0] DC_HEAT_AUTO = 5'h0a;
	localparam logic [4:0] DC_GYRO_AUTO = 5'h0b;
	localparam logic [4:0] DC_MANEUVER = 5'h0c;
	localparam logic [4:0] QC_CONE = 5'h01;
	localparam logic [4:0] QC_TURN = 5'h02;
	localparam logic [4:0] SC_PITCH_POS = 5'h06;
	localparam logic [4:0] SC_PITCH_NEG = 5'h07;
	// register word indices
	localparam logic [3:0] IDX_STATUS = 4'h0;
	localparam logic [3:0] IDX_CONE = 4'h1;
	localparam logic [3:0] IDX_TURN = 4'h2;
	localparam logic [3:0] IDX_REJECT = 4'h3;
	localparam logic [3:0] IDX_CFG = 4'h4;
	// status bit positions
	localparam int ST_ENABLE = 0;
	localparam int ST_HI = 1;
	localparam int ST_LO = 2;
	localparam int ST_RS_AUTO = 3;
	localparam int ST_RS_BYP = 4;
	localparam int ST_CAL = 5;
	localparam int ST_SS_AUTO = 6;
	localparam int ST_SS_BYP = 7;
	localparam int ST_HT_AUTO = 8;
	localparam int ST_HT_BYP = 9;
	localparam int ST_GY_AUTO = 10;
	localparam int ST_GY_BYP = 11;
	localparam int ST_M_ALL = 12;
	localparam int ST_M_PY = 13;
	localparam int ST_MAN = 14;
	// reset value and reject counter limit
	localparam logic [3:0] STEP_RST = 4'h1;
	localparam logic [7:0] REJ_MAX = 8'hff;
endpackage : acl_pkg

// >>> hdl/acl_mode_sel.sv
/*
 auto/bypass selector for one powered or searched function.
 assumes flags and automatic demand are synchronous to clk.
*/
`timescale 1ns/10ps
module acl_mode_sel (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	// selection
	input wire logic auto_flag,
	input wire logic bypass_flag,
	input wire logic auto_req,
	// result
	output logic out_q
);
	// bypass set: the auto flag is the commanded state; else logic unit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_q <= 1'b0;
		end else if (en) begin
			out_q <= bypass_flag ? auto_flag : auto_req;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	mode_follow_a: assert property (en |=>
		out_q == ($past(bypass_flag) ? $past(auto_flag) : $past(auto_req)))
		else $error("selector output does not follow its mode");
endmodule : acl_mode_sel

// >>> hdl/acl_cone.sv
/*
 star sensor cone angle register: direct load and saturating steps.
 assumes at most one of load, up and down per cycle.
*/
`timescale 1ns/10ps
module acl_cone #(
	parameter int W = 8
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	// commands
	input wire logic load,
	input wire logic [W-1:0] load_val,
	input wire logic step_up,
	input wire logic step_dn,
	input wire logic [3:0] step_size,
	// angle
	output logic [W-1:0] angle_q
);
	logic [W:0] up_sum;
	logic [W-1:0] step_w;
	assign step_w = W'(step_size);
	assign up_sum = {1'b0, angle_q} + {1'b0, step_w};

	// saturate rather than wrap: a wrap would swing the sensor across range
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			angle_q <= '0;
		end else if (en) begin
			if (load) begin
				angle_q <= load_val;
			end else if (step_up) begin
				angle_q <= up_sum[W] ? '1 : up_sum[W-1:0];
			end else if (step_dn) begin
				angle_q <= (angle_q < step_w) ? '0 : angle_q - step_w;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	cone_load_a: assert property (en && load
		|=> angle_q == $past(load_val))
		else $error("cone angle not loaded");
	cone_step_a: assert property (en && step_up && !load
		&& !up_sum[W] |=> angle_q == $past(angle_q) + $past(step_w))
		else $error("cone angle step up wrong");
endmodule : acl_cone

// >>> hdl/acl_top.sv
/*
 attitude command logic: accepts commands from the sequencer and the
 ground decoder, holds mode flags, drives cone angle and turn starts.
 assumes all inputs synchronous to CORE_CLK and command valids that
 are one cycle long per command.
*/
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module acl_top #(
	parameter int CONE_W = 8,
	parameter int DATA_W = 16
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RESETN,
	input wire logic CLK_EN,
	// sequencer command port
	input wire logic SEQ_CMD_VALID,
	input wire logic [1:0] SEQ_CMD_CLASS,
	input wire logic [4:0] SEQ_CMD_CODE,
	// decoder command port
	input wire logic DEC_CMD_VALID,
	input wire logic [1:0] DEC_CMD_CLASS,
	input wire logic [4:0] DEC_CMD_CODE,
	input wire logic [DATA_W-1:0] DEC_CMD_DATA,
	// separation switch and automatic demands of the logic unit
	input wire logic STAGE_SEP,
	input wire logic AUTO_ROLL_SEARCH,
	input wire logic AUTO_SENSOR_PWR,
	input wire logic AUTO_HEATER,
	input wire logic AUTO_GYRO,
	input wire logic AUTO_INERTIAL,
	input wire logic MANEUVER_DONE,
	// register port
	input wire logic [3:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	// control outputs
	output logic ACS_ENABLE,
	output logic HIGH_GATE_OVR,
	output logic LOW_GATE_OVR,
	output logic ROLL_SEARCH_ON,
	output logic ROLL_CAL_MODE,
	output logic SENSOR_PWR_ON,
	output logic ROLL_RESTART,
	output logic [CONE_W-1:0] CONE_ANGLE,
	output logic HEATER_ON,
	output logic GYRO_PWR_ON,
	output logic ROLL_INERTIAL,
	output logic PY_INERTIAL,
	output logic [DATA_W-1:0] TURN_WORD,
	output logic MANEUVER_START,
	output logic MANEUVER_ACTIVE,
	output logic PITCH_TURN_POS,
	output logic PITCH_TURN_NEG
);
	typedef enum logic {MAN_IDLE, MAN_TURN} acl_man_t;

	logic dec_ok, seq_ok, cmd_ok, seq_lost;
	logic [1:0] cls;
	logic [4:0] code;
	logic en_q, hi_q, lo_q, cal_q;
	logic rs_auto_q, rs_byp_q, ss_auto_q, ss_byp_q;
	logic ht_auto_q, ht_byp_q, gy_auto_q, gy_byp_q;
	logic m_all_q, m_py_q;
	logic h_en, h_cal, h_hbyp, h_gbyp, h_mall, h_mpy, h_up, h_dn;
	logic h_hi, h_lo, h_rsa, h_rsb, h_ssa, h_ssb, h_ovr;
	logic h_hta, h_gya, h_man, h_cone, h_turn, h_pp, h_pn;
	logic reject, rej_clr;
	logic [7:0] rej_q;
	logic [7:0] last_q;
	logic [3:0] step_q;
	logic [DATA_W-1:0] turn_q;
	acl_man_t man_q;
	logic [31:0] status_w;
	logic [31:0] rd_d;

	function automatic logic hit(input logic [1:0] c, input logic [4:0] k);
		hit = cmd_ok && cls == c && code == k;
	endfunction : hit

	// source legality; decoder wins a same-cycle clash
	assign dec_ok = DEC_CMD_VALID && DEC_CMD_CLASS != acl_pkg::CLS_STORED;
	assign seq_ok = SEQ_CMD_VALID && !DEC_CMD_VALID
		&& (SEQ_CMD_CLASS == acl_pkg::CLS_EITHER
		|| SEQ_CMD_CLASS == acl_pkg::CLS_STORED);
	assign seq_lost = SEQ_CMD_VALID && !seq_ok;
	assign cmd_ok = dec_ok || seq_ok;
	assign cls = DEC_CMD_VALID ? DEC_CMD_CLASS : SEQ_CMD_CLASS;
	assign code = DEC_CMD_VALID ? DEC_CMD_CODE : SEQ_CMD_CODE;
	// a second maneuver while one runs is refused and counted
	assign reject = seq_lost || (DEC_CMD_VALID && !dec_ok)
		|| (h_man && (man_q == MAN_TURN || !en_q));

	// a process, not assigns: the decode must re-run when cmd_ok changes
	always_comb begin
		h_en = hit(acl_pkg::CLS_EITHER, acl_pkg::EC_ENABLE);
		h_cal = hit(acl_pkg::CLS_EITHER, acl_pkg::EC_ROLL_MODE);
		h_hbyp = hit(acl_pkg::CLS_EITHER, acl_pkg::EC_HEAT_BYP);
		h_gbyp = hit(acl_pkg::CLS_EITHER, acl_pkg::EC_GYRO_BYP);
		h_mall = hit(acl_pkg::CLS_EITHER, acl_pkg::EC_MODE_ALL);
		h_mpy = hit(acl_pkg::CLS_EITHER, acl_pkg::EC_MODE_PY);
		h_up = hit(acl_pkg::CLS_EITHER, acl_pkg::EC_CONE_UP);
		h_dn = hit(acl_pkg::CLS_EITHER, acl_pkg::EC_CONE_DN);
		h_hi = hit(acl_pkg::CLS_DECODER, acl_pkg::DC_HI_GATE);
		h_lo = hit(acl_pkg::CLS_DECODER, acl_pkg::DC_LO_GATE);
		h_rsa = hit(acl_pkg::CLS_DECODER, acl_pkg::DC_RS_AUTO);
		h_rsb = hit(acl_pkg::CLS_DECODER, acl_pkg::DC_RS_BYP);
		h_ssa = hit(acl_pkg::CLS_DECODER, acl_pkg::DC_SS_AUTO);
		h_ssb = hit(acl_pkg::CLS_DECODER, acl_pkg::DC_SS_BYP);
		h_ovr = hit(acl_pkg::CLS_DECODER, acl_pkg::DC_ROLL_OVR);
		h_hta = hit(acl_pkg::CLS_DECODER, acl_pkg::DC_HEAT_AUTO);
		h_gya = hit(acl_pkg::CLS_DECODER, acl_pkg::DC_GYRO_AUTO);
		h_man = hit(acl_pkg::CLS_DECODER, acl_pkg::DC_MANEUVER);
		h_cone = hit(acl_pkg::CLS_QUANT, acl_pkg::QC_CONE);
		h_turn = hit(acl_pkg::CLS_QUANT, acl_pkg::QC_TURN);
		h_pp = hit(acl_pkg::CLS_STORED, acl_pkg::SC_PITCH_POS);
		h_pn = hit(acl_pkg::CLS_STORED, acl_pkg::SC_PITCH_NEG);
	end

	// enable state: separation switch forces enable, command toggles
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			en_q <= 1'b0;
		end else if (CLK_EN) begin
			if (STAGE_SEP) begin
				en_q <= 1'b1;
			end else if (h_en) begin
				en_q <= ~en_q;
			end
		end
	end

	// change-state flags, each toggled only by its own code
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			hi_q <= 1'b0;
			lo_q <= 1'b0;
			cal_q <= 1'b0;
			rs_auto_q <= 1'b0;
			rs_byp_q <= 1'b0;
			ss_auto_q <= 1'b0;
			ss_byp_q <= 1'b0;
			ht_auto_q <= 1'b0;
			ht_byp_q <= 1'b0;
			gy_auto_q <= 1'b0;
			gy_byp_q <= 1'b0;
			m_all_q <= 1'b0;
			m_py_q <= 1'b0;
		end else if (CLK_EN) begin
			hi_q <= hi_q ^ h_hi;
			lo_q <= lo_q ^ h_lo;
			cal_q <= cal_q ^ h_cal;
			rs_auto_q <= rs_auto_q ^ h_rsa;
			rs_byp_q <= rs_byp_q ^ h_rsb;
			ss_auto_q <= ss_auto_q ^ h_ssa;
			ss_byp_q <= ss_byp_q ^ h_ssb;
			ht_auto_q <= ht_auto_q ^ h_hta;
			ht_byp_q <= ht_byp_q ^ h_hbyp;
			gy_auto_q <= gy_auto_q ^ h_gya;
			gy_byp_q <= gy_byp_q ^ h_gbyp;
			m_all_q <= m_all_q ^ h_mall;
			m_py_q <= m_py_q ^ h_mpy;
		end
	end

	// flag outputs registered so they match the other outputs in timing
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			ACS_ENABLE <= 1'b0;
			HIGH_GATE_OVR <= 1'b0;
			LOW_GATE_OVR <= 1'b0;
			ROLL_CAL_MODE <= 1'b0;
		end else if (CLK_EN) begin
			ACS_ENABLE <= STAGE_SEP || (en_q ^ h_en);
			HIGH_GATE_OVR <= hi_q ^ h_hi;
			LOW_GATE_OVR <= lo_q ^ h_lo;
			ROLL_CAL_MODE <= cal_q ^ h_cal;
		end
	end

	// control mode: 00 automatic, 10 inertial, 01 pitch/yaw inertial,
	// 11 commanded cruise/acquisition on every axis
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			ROLL_INERTIAL <= 1'b0;
			PY_INERTIAL <= 1'b0;
		end else if (CLK_EN) begin
			unique case ({m_all_q, m_py_q})
				2'b00: begin
					ROLL_INERTIAL <= AUTO_INERTIAL;
					PY_INERTIAL <= AUTO_INERTIAL;
				end
				2'b10: begin
					ROLL_INERTIAL <= 1'b1;
					PY_INERTIAL <= 1'b1;
				end
				2'b01: begin
					ROLL_INERTIAL <= 1'b0;
					PY_INERTIAL <= 1'b1;
				end
				2'b11: begin
					ROLL_INERTIAL <= 1'b0;
					PY_INERTIAL <= 1'b0;
				end
			endcase
		end
	end

	// automatic roll search only runs while control is enabled
	acl_mode_sel u_roll (
		.clk(CORE_CLK),
		.rst_n(RESETN),
		.en(CLK_EN),
		.auto_flag(rs_auto_q),
		.bypass_flag(rs_byp_q),
		.auto_req(AUTO_ROLL_SEARCH && en_q),
		.out_q(ROLL_SEARCH_ON)
	);
	acl_mode_sel u_sensor (
		.clk(CORE_CLK),
		.rst_n(RESETN),
		.en(CLK_EN),
		.auto_flag(ss_auto_q),
		.bypass_flag(ss_byp_q),
		.auto_req(AUTO_SENSOR_PWR),
		.out_q(SENSOR_PWR_ON)
	);
	acl_mode_sel u_heater (
		.clk(CORE_CLK),
		.rst_n(RESETN),
		.en(CLK_EN),
		.auto_flag(ht_auto_q),
		.bypass_flag(ht_byp_q),
		.auto_req(AUTO_HEATER),
		.out_q(HEATER_ON)
	);
	acl_mode_sel u_gyro (
		.clk(CORE_CLK),
		.rst_n(RESETN),
		.en(CLK_EN),
		.auto_flag(gy_auto_q),
		.bypass_flag(gy_byp_q),
		.auto_req(AUTO_GYRO),
		.out_q(GYRO_PWR_ON)
	);

	acl_cone #(.W(CONE_W)) u_cone (
		.clk(CORE_CLK),
		.rst_n(RESETN),
		.en(CLK_EN),
		.load(h_cone),
		.load_val(DEC_CMD_DATA[CONE_W-1:0]),
		.step_up(h_up),
		.step_dn(h_dn),
		.step_size(step_q),
		.angle_q(CONE_ANGLE)
	);

	// one-cycle control pulses, suppressed while inhibited
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			ROLL_RESTART <= 1'b0;
			PITCH_TURN_POS <= 1'b0;
			PITCH_TURN_NEG <= 1'b0;
		end else if (CLK_EN) begin
			ROLL_RESTART <= h_ovr && en_q;
			PITCH_TURN_POS <= h_pp && en_q;
			PITCH_TURN_NEG <= h_pn && en_q;
		end
	end

	// turn register; relies on the decoder loading it first
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			turn_q <= '0;
		end else if (CLK_EN && h_turn) begin
			turn_q <= DEC_CMD_DATA;
		end
	end

	// maneuver sequence
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			man_q <= MAN_IDLE;
			MANEUVER_START <= 1'b0;
			MANEUVER_ACTIVE <= 1'b0;
			TURN_WORD <= '0;
		end else if (CLK_EN) begin
			MANEUVER_START <= 1'b0;
			unique case (man_q)
				MAN_IDLE: begin
					if (h_man && en_q) begin
						man_q <= MAN_TURN;
						MANEUVER_START <= 1'b1;
						MANEUVER_ACTIVE <= 1'b1;
						TURN_WORD <= turn_q;
					end
				end
				MAN_TURN: begin
					// inhibit aborts the maneuver
					if (MANEUVER_DONE || !en_q) begin
						man_q <= MAN_IDLE;
						MANEUVER_ACTIVE <= 1'b0;
					end
				end
			endcase
		end
	end

	// reject counter: an event in the clearing cycle still counts
	assign rej_clr = REG_WR && REG_ADDR == acl_pkg::IDX_REJECT;
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rej_q <= '0;
			last_q <= '0;
		end else if (CLK_EN) begin
			if (reject) begin
				rej_q <= rej_clr ? 8'h01
					: (rej_q == acl_pkg::REJ_MAX ? rej_q : rej_q + 8'h01);
			end else if (rej_clr) begin
				rej_q <= '0;
			end
			if (cmd_ok) begin
				last_q <= {DEC_CMD_VALID, cls, code};
			end
		end
	end

	// configuration: cone step size
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			step_q <= acl_pkg::STEP_RST;
		end else if (CLK_EN && REG_WR && REG_ADDR == acl_pkg::IDX_CFG) begin
			step_q <= REG_WDATA[3:0];
		end
	end

	always_comb begin
		status_w = '0;
		status_w[acl_pkg::ST_ENABLE] = en_q;
		status_w[acl_pkg::ST_HI] = hi_q;
		status_w[acl_pkg::ST_LO] = lo_q;
		status_w[acl_pkg::ST_RS_AUTO] = rs_auto_q;
		status_w[acl_pkg::ST_RS_BYP] = rs_byp_q;
		status_w[acl_pkg::ST_CAL] = cal_q;
		status_w[acl_pkg::ST_SS_AUTO] = ss_auto_q;
		status_w[acl_pkg::ST_SS_BYP] = ss_byp_q;
		status_w[acl_pkg::ST_HT_AUTO] = ht_auto_q;
		status_w[acl_pkg::ST_HT_BYP] = ht_byp_q;
		status_w[acl_pkg::ST_GY_AUTO] = gy_auto_q;
		status_w[acl_pkg::ST_GY_BYP] = gy_byp_q;
		status_w[acl_pkg::ST_M_ALL] = m_all_q;
		status_w[acl_pkg::ST_M_PY] = m_py_q;
		status_w[acl_pkg::ST_MAN] = man_q == MAN_TURN;
	end

	always_comb begin
		rd_d = '0;
		unique case (REG_ADDR)
			acl_pkg::IDX_STATUS: rd_d = status_w;
			acl_pkg::IDX_CONE: rd_d = 32'(CONE_ANGLE);
			acl_pkg::IDX_TURN: rd_d = 32'(turn_q);
			acl_pkg::IDX_REJECT: rd_d = {16'h0000, last_q, rej_q};
			acl_pkg::IDX_CFG: rd_d = {28'h000_0000, step_q};
			default: rd_d = '0;
		endcase
	end

	// read data stand for one cycle only
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			REG_RDATA <= '0;
		end else if (CLK_EN) begin
			REG_RDATA <= REG_RD ? rd_d : '0;
		end
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);

	enable_toggle_a: assert property (CLK_EN && h_en && !STAGE_SEP
		|=> en_q != $past(en_q))
		else $error("enable state did not toggle");
	pulse_gate_a: assert property (ROLL_RESTART || PITCH_TURN_POS
		|-> $past(en_q))
		else $error("control pulse while inhibited");
	high_gate_a: assert property (CLK_EN && h_hi
		|=> HIGH_GATE_OVR != $past(HIGH_GATE_OVR))
		else $error("high gate override did not toggle");
	low_gate_a: assert property (CLK_EN && h_lo
		|=> LOW_GATE_OVR == !$past(lo_q))
		else $error("low gate override did not toggle");
	roll_mode_a: assert property (CLK_EN && h_cal
		|=> ROLL_CAL_MODE != $past(cal_q))
		else $error("roll turn mode did not toggle");
	override_a: assert property (CLK_EN && h_ovr && en_q
		|=> ROLL_RESTART ##1 (!ROLL_RESTART || $past(h_ovr)))
		else $error("roll override pulse wrong");
	inertial_a: assert property (CLK_EN && m_all_q && !m_py_q
		|=> ROLL_INERTIAL && PY_INERTIAL)
		else $error("commanded inertial mode not driven");
	maneuver_a: assert property (CLK_EN && h_man && en_q
		&& man_q == MAN_IDLE
		|=> MANEUVER_START && MANEUVER_ACTIVE && TURN_WORD == $past(turn_q))
		else $error("maneuver did not start with stored turns");
	pitch_a: assert property (CLK_EN && h_pn && en_q
		|=> PITCH_TURN_NEG && !PITCH_TURN_POS)
		else $error("negative pitch turn not started");
	source_a: assert property (CLK_EN && SEQ_CMD_VALID && !DEC_CMD_VALID
		&& SEQ_CMD_CLASS == acl_pkg::CLS_DECODER
		|=> $stable(hi_q) && $stable(lo_q) && !ROLL_RESTART)
		else $error("decoder-only command taken from sequencer");
	hold_a: assert property (CLK_EN && !cmd_ok
		|=> $stable(hi_q) && $stable(m_all_q) && $stable(gy_byp_q))
		else $error("flag changed with no command");

	man_c: cover property (CLK_EN && h_turn ##[1:20] MANEUVER_START);
	cone_c: cover property (CLK_EN && h_cone ##[1:10] CLK_EN && h_up);
	sep_c: cover property (STAGE_SEP ##1 ACS_ENABLE ##[1:10] ROLL_RESTART);
endmodule : acl_top

// >>> tb/acl_cmd_src.sv
/*
 model of the sequencer and ground decoder command ports.
 assumes the bench calls send from one process at a time.
*/
`timescale 1ns/10ps
module acl_cmd_src (
	// clock
	input wire logic clk,
	// sequencer port
	output logic seq_valid,
	output logic [1:0] seq_class,
	output logic [4:0] seq_code,
	// decoder port
	output logic dec_valid,
	output logic [1:0] dec_class,
	output logic [4:0] dec_code,
	output logic [15:0] dec_data
);
	initial begin
		{seq_valid, dec_valid} = 2'h0;
		{seq_class, seq_code, dec_class, dec_code} = 14'h0000;
		dec_data = 16'h0000;
	end
	task send(input logic dec, input logic [1:0] cls, input logic [4:0] code,
		input logic [15:0] data);
		@(posedge clk);
		if (dec) begin
			dec_valid <= 1'h1;
			dec_class <= cls;
			dec_code <= code;
			dec_data <= data;
		end else begin
			seq_valid <= 1'h1;
			seq_class <= cls;
			seq_code <= code;
		end
		@(posedge clk);
		// released fields turn over so a stale word never looks valid
		{seq_valid, dec_valid} <= 2'h0;
		{seq_class, seq_code} <= ~{seq_class, seq_code};
		{dec_class, dec_code, dec_data} <= ~{dec_class, dec_code, dec_data};
	endtask : send
endmodule : acl_cmd_src

// >>> tb/tb_acl_top.sv
/*
 self-checking bench of the attitude command logic.
 assumes the command port model acl_cmd_src and the acl_pkg codes.
*/
`timescale 1ns/10ps
module tb_acl_top;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic sv, dv, sep = 1'h0, a_rs = 1'h0, a_ss = 1'h0, a_ht = 1'h0;
	logic a_gy = 1'h0, a_in = 1'h0, done = 1'h0, wr = 1'h0, rd = 1'h0;
	logic [1:0] sc, dc;
	logic [4:0] so, dco;
	logic [15:0] dd, turn;
	logic [3:0] addr = 4'h0;
	logic ce = 1'h1;
	logic [31:0] wd = 32'h0000_0000, rdat, rv;
	logic en, hi, lo, rs, cal, ss, rst_p, ht, gy, r_in, py_in;
	logic [7:0] cone;
	logic m_st, m_act, p_pos, p_neg;
	int mismatches = 0;
	int checks_done = 0;
	always #2.5 clk = ~clk;
	acl_cmd_src u_src (.clk(clk), .seq_valid(sv), .seq_class(sc),
		.seq_code(so), .dec_valid(dv), .dec_class(dc), .dec_code(dco),
		.dec_data(dd));
	acl_top u_dut (.CORE_CLK(clk), .RESETN(rst_n), .CLK_EN(ce),
		.SEQ_CMD_VALID(sv), .SEQ_CMD_CLASS(sc), .SEQ_CMD_CODE(so),
		.DEC_CMD_VALID(dv), .DEC_CMD_CLASS(dc), .DEC_CMD_CODE(dco),
		.DEC_CMD_DATA(dd), .STAGE_SEP(sep), .AUTO_ROLL_SEARCH(a_rs),
		.AUTO_SENSOR_PWR(a_ss), .AUTO_HEATER(a_ht), .AUTO_GYRO(a_gy),
		.AUTO_INERTIAL(a_in), .MANEUVER_DONE(done), .REG_ADDR(addr),
		.REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat),
		.ACS_ENABLE(en), .HIGH_GATE_OVR(hi), .LOW_GATE_OVR(lo),
		.ROLL_SEARCH_ON(rs), .ROLL_CAL_MODE(cal), .SENSOR_PWR_ON(ss),
		.ROLL_RESTART(rst_p), .CONE_ANGLE(cone), .HEATER_ON(ht),
		.GYRO_PWR_ON(gy), .ROLL_INERTIAL(r_in), .PY_INERTIAL(py_in),
		.TURN_WORD(turn), .MANEUVER_START(m_st), .MANEUVER_ACTIVE(m_act),
		.PITCH_TURN_POS(p_pos), .PITCH_TURN_NEG(p_neg));
	task print_verdict;
		$display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task cmd(input logic d, input logic [1:0] c, input logic [4:0] k,
		input logic [15:0] v);
		u_src.send(d, c, k, v);
		#1;
	endtask : cmd
	task rreg(input logic [3:0] a);
		@(posedge clk);
		rd <= 1'h1;
		addr <= a;
		@(posedge clk);
		rd <= 1'h0;
		#1;
		rv = rdat;
	endtask : rreg
	task wreg(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'h1;
		addr <= a;
		wd <= v;
		@(posedge clk);
		wr <= 1'h0;
	endtask : wreg
	// toggle one flag twice, watching its status bit rise and fall
	task tog(input logic [1:0] c, input logic [4:0] k, input int b);
		cmd(c != acl_pkg::CLS_EITHER, c, k, 16'h0000);
		rreg(acl_pkg::IDX_STATUS);
		cmp(rv, 32'h0000_0001 | (32'h0000_0001 << b));
		cmd(c != acl_pkg::CLS_EITHER, c, k, 16'h0000);
		rreg(acl_pkg::IDX_STATUS);
		cmp(rv, 32'h0000_0001);
	endtask : tog
	task quad(input logic byp);
		cmd(1'h1, 2'h2, byp ? acl_pkg::DC_RS_BYP : acl_pkg::DC_RS_AUTO, 16'h0000);
		cmd(1'h1, 2'h2, byp ? acl_pkg::DC_SS_BYP : acl_pkg::DC_SS_AUTO, 16'h0000);
		cmd(!byp, byp ? 2'h1 : 2'h2,
			byp ? acl_pkg::EC_HEAT_BYP : acl_pkg::DC_HEAT_AUTO, 16'h0000);
		cmd(!byp, byp ? 2'h1 : 2'h2,
			byp ? acl_pkg::EC_GYRO_BYP : acl_pkg::DC_GYRO_AUTO, 16'h0000);
		// selector output is registered behind its flag: one more cycle
		cyc(1);
	endtask : quad
	task autos(input logic v);
		@(posedge clk);
		{a_rs, a_ss, a_ht, a_gy} <= {4{v}};
	endtask : autos
	initial begin
		#200000;
		mismatches++;
		print_verdict();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		cyc(1);
		rreg(acl_pkg::IDX_CFG);
		cmp(rv, 32'h0000_0001);
		wreg(acl_pkg::IDX_STATUS, 32'hffff_ffff);
		rreg(acl_pkg::IDX_STATUS);
		cmp(rv, 32'h0000_0000);
		rreg(4'hf);
		cmp(rv, 32'h0000_0000);
		cmd(1'h0, acl_pkg::CLS_EITHER, acl_pkg::EC_ENABLE, 16'h0000);
		cmp(32'(en), 32'h0000_0001);
		tog(2'h2, acl_pkg::DC_HI_GATE, acl_pkg::ST_HI);
		tog(2'h2, acl_pkg::DC_LO_GATE, acl_pkg::ST_LO);
		tog(2'h2, acl_pkg::DC_RS_AUTO, acl_pkg::ST_RS_AUTO);
		tog(2'h2, acl_pkg::DC_RS_BYP, acl_pkg::ST_RS_BYP);
		tog(2'h1, acl_pkg::EC_ROLL_MODE, acl_pkg::ST_CAL);
		tog(2'h2, acl_pkg::DC_SS_AUTO, acl_pkg::ST_SS_AUTO);
		tog(2'h2, acl_pkg::DC_SS_BYP, acl_pkg::ST_SS_BYP);
		tog(2'h2, acl_pkg::DC_HEAT_AUTO, acl_pkg::ST_HT_AUTO);
		tog(2'h1, acl_pkg::EC_HEAT_BYP, acl_pkg::ST_HT_BYP);
		tog(2'h2, acl_pkg::DC_GYRO_AUTO, acl_pkg::ST_GY_AUTO);
		tog(2'h1, acl_pkg::EC_GYRO_BYP, acl_pkg::ST_GY_BYP);
		tog(2'h1, acl_pkg::EC_MODE_ALL, acl_pkg::ST_M_ALL);
		tog(2'h1, acl_pkg::EC_MODE_PY, acl_pkg::ST_M_PY);
		cmd(1'h1, 2'h2, acl_pkg::DC_LO_GATE, 16'h0000);
		cmd(1'h0, 2'h1, acl_pkg::EC_ROLL_MODE, 16'h0000);
		cmp(32'({lo, cal}), 32'h0000_0003);
		quad(1'h0);
		quad(1'h1);
		cmp(32'({rs, ss, ht, gy}), 32'h0000_000f);
		quad(1'h0);
		cmp(32'({rs, ss, ht, gy}), 32'h0000_0000);
		autos(1'h1);
		quad(1'h1);
		cmp(32'({rs, ss, ht, gy}), 32'h0000_000f);
		autos(1'h0);
		cyc(2);
		cmp(32'({rs, ss, ht, gy}), 32'h0000_0000);
		cmd(1'h0, acl_pkg::CLS_EITHER, acl_pkg::EC_MODE_ALL, 16'h0000);
		cyc(1);
		cmp(32'({r_in, py_in}), 32'h0000_0003);
		cmd(1'h0, acl_pkg::CLS_EITHER, acl_pkg::EC_MODE_PY, 16'h0000);
		cyc(1);
		cmp(32'({r_in, py_in}), 32'h0000_0000);
		cmd(1'h0, acl_pkg::CLS_EITHER, acl_pkg::EC_MODE_ALL, 16'h0000);
		cyc(1);
		cmp(32'({r_in, py_in}), 32'h0000_0001);
		cmd(1'h0, acl_pkg::CLS_EITHER, acl_pkg::EC_MODE_PY, 16'h0000);
		@(posedge clk);
		a_in <= 1'h1;
		cyc(2);
		cmp(32'({r_in, py_in}), 32'h0000_0003);
		cmd(1'h1, 2'h2, acl_pkg::DC_ROLL_OVR, 16'h0000);
		cmp(32'(rst_p), 32'h0000_0001);
		cyc(1);
		cmp(32'(rst_p), 32'h0000_0000);
		cmd(1'h1, acl_pkg::CLS_QUANT, acl_pkg::QC_CONE, 16'h00fe);
		cmp(32'(cone), 32'h0000_00fe);
		cmd(1'h0, 2'h1, acl_pkg::EC_CONE_UP, 16'h0000);
		cmd(1'h0, 2'h1, acl_pkg::EC_CONE_UP, 16'h0000);
		cmp(32'(cone), 32'h0000_00ff);
		wreg(acl_pkg::IDX_CFG, 32'h0000_0002);
		cmd(1'h0, 2'h1, acl_pkg::EC_CONE_DN, 16'h0000);
		rreg(acl_pkg::IDX_CONE);
		cmp(rv, 32'h0000_00fd);
		wreg(acl_pkg::IDX_REJECT, 32'h0000_0000);
		cmd(1'h0, 2'h2, acl_pkg::DC_HI_GATE, 16'h0000);
		cmd(1'h1, 2'h3, acl_pkg::SC_PITCH_POS, 16'h0000);
		cmp(32'({hi, p_pos}), 32'h0000_0000);
		cmd(1'h1, 2'h0, acl_pkg::QC_TURN, 16'ha5c3);
		cmd(1'h1, 2'h2, acl_pkg::DC_MANEUVER, 16'h0000);
		cmp(32'({m_st, m_act, turn}), 32'h0003_a5c3);
		cyc(1);
		cmd(1'h1, 2'h2, acl_pkg::DC_MANEUVER, 16'h0000);
		cmp(32'({m_st, m_act}), 32'h0000_0001);
		rreg(acl_pkg::IDX_REJECT);
		cmp(rv, 32'h0000_cc03);
		@(posedge clk);
		done <= 1'h1;
		@(posedge clk);
		done <= 1'h0;
		cyc(2);
		cmp(32'(m_act), 32'h0000_0000);
		cmd(1'h0, 2'h3, acl_pkg::SC_PITCH_POS, 16'h0000);
		cmp(32'({p_pos, p_neg}), 32'h0000_0002);
		cmd(1'h0, 2'h3, acl_pkg::SC_PITCH_NEG, 16'h0000);
		cmp(32'({p_pos, p_neg}), 32'h0000_0001);
		cmd(1'h0, 2'h1, acl_pkg::EC_ENABLE, 16'h0000);
		cmd(1'h0, 2'h3, acl_pkg::SC_PITCH_POS, 16'h0000);
		cmp(32'({en, p_pos}), 32'h0000_0000);
		@(posedge clk);
		sep <= 1'h1;
		@(posedge clk);
		sep <= 1'h0;
		cyc(2);
		cmp(32'(en), 32'h0000_0001);
		// a frozen clock enable must swallow a toggle command
		@(posedge clk);
		ce <= 1'h0;
		cmd(1'h0, 2'h1, acl_pkg::EC_ENABLE, 16'h0000);
		cmp(32'(en), 32'h0000_0001);
		@(posedge clk);
		ce <= 1'h1;
		print_verdict();
	end
endmodule : tb_acl_top
